// ### rtl/dua_chan.sv
`timescale 1ns/1ps
`include "dua_cfg.svh"
module dua_chan (
    // Clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_rst,
    // Register access
    dua_chan_if.chan  bus
);
    dua_pkg::dua_byte_t ier_r, ier_nxt, lcr_r, lcr_nxt, mcr_r, mcr_nxt;
    dua_pkg::dua_byte_t fcr_r, fcr_nxt, spr_r, spr_nxt, dll_r, dll_nxt;
    dua_pkg::dua_byte_t dlm_r, dlm_nxt, isr_r, lsr_r;
    logic [3:0]         delta_r, delta_nxt, prev_r;
    logic               primed_r;
    logic [3:0]         change;
    logic               dlab;

    // ----------------------------------------
    // Register next values
    // ----------------------------------------
    always_comb begin
        ier_nxt = ier_r;
        lcr_nxt = lcr_r;
        mcr_nxt = mcr_r;
        fcr_nxt = fcr_r;
        spr_nxt = spr_r;
        dll_nxt = dll_r;
        dlm_nxt = dlm_r;
        dlab    = lcr_r[`DUA_LCR_DLAB_BIT];
        if (bus.we) begin
            if (bus.addr == `DUA_OFF_DATA && dlab) begin
                dll_nxt = bus.wdata;
            end else if (bus.addr == `DUA_OFF_IER) begin
                if (dlab) begin
                    dlm_nxt = bus.wdata;
                end else begin
                    ier_nxt = bus.wdata;
                end
            end else if (bus.addr == `DUA_OFF_ISR_FCR && !dlab) begin
                fcr_nxt = bus.wdata;
            end else if (bus.addr == `DUA_OFF_LCR) begin
                lcr_nxt = bus.wdata;
            end else if (bus.addr == `DUA_OFF_MCR) begin
                mcr_nxt = bus.wdata;
            end else if (bus.addr == `DUA_OFF_SCRATCH) begin
                spr_nxt = bus.wdata;
            end
        end
        // Change bits: set wins over the clear of a read in the same cycle
        change = primed_r ? (prev_r ^ bus.modem_n) : 4'h0;
        change[`DUA_MSR_RI_BIT] = primed_r & ~prev_r[`DUA_MSR_RI_BIT]
                                  & bus.modem_n[`DUA_MSR_RI_BIT];
        delta_nxt = delta_r;
        if (bus.re && bus.addr == `DUA_OFF_MSR) begin
            delta_nxt = 4'h0;
        end
        delta_nxt = delta_nxt | change;
    end

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            ier_r    <= `DUA_RST_ZERO;
            lcr_r    <= `DUA_RST_ZERO;
            mcr_r    <= `DUA_RST_ZERO;
            fcr_r    <= `DUA_RST_ZERO;
            spr_r    <= `DUA_RST_ZERO;
            dll_r    <= `DUA_RST_ZERO;
            dlm_r    <= `DUA_RST_ZERO;
            isr_r    <= `DUA_RST_ISR;
            lsr_r    <= `DUA_RST_LSR;
            delta_r  <= 4'h0;
            prev_r   <= 4'h0;
            primed_r <= 1'b0;
        end else begin
            ier_r    <= ier_nxt;
            lcr_r    <= lcr_nxt;
            mcr_r    <= mcr_nxt;
            fcr_r    <= fcr_nxt;
            spr_r    <= spr_nxt;
            dll_r    <= dll_nxt;
            dlm_r    <= dlm_nxt;
            isr_r    <= bus.int_status;
            lsr_r    <= bus.line_status;
            delta_r  <= delta_nxt;
            prev_r   <= bus.modem_n;
            primed_r <= 1'b1;  // First sample after reset sets no change bit
        end
    end

    // ----------------------------------------
    // Read data; modem levels are live so reset shows the inputs at once
    // ----------------------------------------
    always_comb begin
        if (bus.addr == `DUA_OFF_DATA) begin
            bus.rdata = lcr_r[`DUA_LCR_DLAB_BIT] ? dll_r : `DUA_RST_ZERO;
        end else if (bus.addr == `DUA_OFF_IER) begin
            bus.rdata = lcr_r[`DUA_LCR_DLAB_BIT] ? dlm_r : ier_r;
        end else if (bus.addr == `DUA_OFF_ISR_FCR) begin
            bus.rdata = isr_r;
        end else if (bus.addr == `DUA_OFF_LCR) begin
            bus.rdata = lcr_r;
        end else if (bus.addr == `DUA_OFF_MCR) begin
            bus.rdata = mcr_r;
        end else if (bus.addr == `DUA_OFF_LSR) begin
            bus.rdata = lsr_r;
        end else if (bus.addr == `DUA_OFF_MSR) begin
            bus.rdata = {~bus.modem_n, delta_r};
        end else begin
            bus.rdata = spr_r;
        end
    end

    assign bus.line_control_register = lcr_r;
    assign bus.modem_control_register = mcr_r;
endmodule : dua_chan

// ### rtl/dua_top.sv
`timescale 1ns/1ps
`include "dua_cfg.svh"
module dua_top (
    // Clock and reset
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    // Host register port
    input  wire logic       i_channel_select,
    input  wire logic [2:0] i_addr,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    input  wire logic [7:0] i_wdata,
    output logic      [7:0] o_rdata,
    // Channel A datapath and modem side
    input  wire logic [3:0] i_modem_n_a,
    input  wire logic [7:0] i_int_status_a,
    input  wire logic [7:0] i_line_status_a,
    input  wire logic       i_tx_serial_a,
    input  wire logic       i_int_req_a,
    input  wire logic       i_tx_ready_a,
    input  wire logic       i_rx_ready_a,
    input  wire logic       i_baud_clk_a,
    // Channel B datapath and modem side
    input  wire logic [3:0] i_modem_n_b,
    input  wire logic [7:0] i_int_status_b,
    input  wire logic [7:0] i_line_status_b,
    input  wire logic       i_tx_serial_b,
    input  wire logic       i_int_req_b,
    input  wire logic       i_tx_ready_b,
    input  wire logic       i_rx_ready_b,
    input  wire logic       i_baud_clk_b,
    // Channel A pins
    output logic            o_serial_transmit_a,
    output logic            o_user_output_two_a,
    output logic            o_request_to_send_a,
    output logic            o_terminal_ready_a,
    output logic            o_interrupt_out_a,
    output logic            o_transmit_ready_a,
    output logic            o_multi_function_out_a,
    // Channel B pins
    output logic            o_serial_transmit_b,
    output logic            o_user_output_two_b,
    output logic            o_request_to_send_b,
    output logic            o_terminal_ready_b,
    output logic            o_interrupt_out_b,
    output logic            o_transmit_ready_b,
    output logic            o_multi_function_out_b
);
    dua_chan_if         ch_if [2] ();
    dua_pkg::dua_byte_t afr_r, afr_nxt, rdata_r, rdata_nxt;
    logic [6:0]         pins_r [2];
    logic [6:0]         pins_nxt [2];
    logic [1:0]         tx_in, int_in, txr_in, rxr_in, baud_in;
    dua_pkg::dua_byte_t sel_lcr, sel_rdata;
    logic               afr_hit;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Write reaches a channel when selected or when dual write is on
    function automatic logic chan_we(input logic ch, input logic sel, input logic dual);
        chan_we = i_wr && ((sel == ch) || dual);
    endfunction : chan_we

    // Active-low pin level from the selected source
    function automatic logic mf_level(input logic [1:0] sel, input logic op2_n,
                                      input logic baud, input logic rxr);
        dua_pkg::dua_mf_sel_t s;
        s = dua_pkg::dua_mf_sel_t'(sel);
        case (s)
            dua_pkg::DUA_MF_OP2:   mf_level = op2_n;
            dua_pkg::DUA_MF_BAUD:  mf_level = ~baud;
            dua_pkg::DUA_MF_RECEIVE_READY_INDICATION: mf_level = ~rxr;
            default:               mf_level = 1'b1;
        endcase
    endfunction : mf_level

    // ----------------------------------------
    // Channel instances
    // ----------------------------------------
    assign ch_if[0].modem_n     = i_modem_n_a;
    assign ch_if[0].int_status  = i_int_status_a;
    assign ch_if[0].line_status = i_line_status_a;
    assign ch_if[1].modem_n     = i_modem_n_b;
    assign ch_if[1].int_status  = i_int_status_b;
    assign ch_if[1].line_status = i_line_status_b;
    assign tx_in   = {i_tx_serial_b, i_tx_serial_a};
    assign int_in  = {i_int_req_b, i_int_req_a};
    assign txr_in  = {i_tx_ready_b, i_tx_ready_a};
    assign rxr_in  = {i_rx_ready_b, i_rx_ready_a};
    assign baud_in = {i_baud_clk_b, i_baud_clk_a};

    for (genvar c = 0; c < 2; c++) begin : g_chan
        // Reads touch only the selected channel, whatever dual write says
        assign ch_if[c].we    = chan_we(c[0], i_channel_select, afr_r[`DUA_AFR_DUAL_BIT]);
        assign ch_if[c].re    = i_rd && (i_channel_select == c[0]);
        assign ch_if[c].addr  = i_addr;
        assign ch_if[c].wdata = i_wdata;
        dua_chan u_chan (
            .i_core_clk (i_core_clk),
            .i_rst      (i_rst),
            .bus        (ch_if[c])
        );

        // Pin next values: MODEM_CONTROL_REGISTER bits drive active-low pins, so zero reads high
        always_comb begin
            pins_nxt[c] = {tx_in[c],
                           ~ch_if[c].modem_control_register[`DUA_MCR_OP2_BIT],
                           ~ch_if[c].modem_control_register[`DUA_MCR_RTS_BIT],
                           ~ch_if[c].modem_control_register[`DUA_MCR_DTR_BIT],
                           int_in[c],
                           txr_in[c],
                           mf_level(afr_r[`DUA_AFR_MF_HI:`DUA_AFR_MF_LO],
                                    ~ch_if[c].modem_control_register[`DUA_MCR_OP2_BIT],
                                    baud_in[c], rxr_in[c])};
        end

        always_ff @(posedge i_core_clk or posedge i_rst) begin
            if (i_rst) begin
                pins_r[c] <= `DUA_RST_PINS;
            end else begin
                pins_r[c] <= pins_nxt[c];
            end
        end
    end

    // ----------------------------------------
    // Alternate-function register and read port
    // ----------------------------------------
    // The selected channel's divisor bit opens the shared register; with
    // dual write on the host keeps both bits equal
    always_comb begin
        sel_lcr   = i_channel_select ? ch_if[1].line_control_register : ch_if[0].line_control_register;
        sel_rdata = i_channel_select ? ch_if[1].rdata : ch_if[0].rdata;
        afr_hit   = (i_addr == `DUA_OFF_ISR_FCR) && sel_lcr[`DUA_LCR_DLAB_BIT];
        afr_nxt   = afr_r;
        if (i_wr && afr_hit) begin
            afr_nxt = {5'h00, i_wdata[`DUA_AFR_USED-1:0]};
        end
        rdata_nxt = rdata_r;
        if (i_rd) begin
            rdata_nxt = afr_hit ? afr_r : sel_rdata;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            afr_r   <= `DUA_RST_ZERO;
            rdata_r <= `DUA_RST_ZERO;
        end else begin
            afr_r   <= afr_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ----------------------------------------
    // Outputs, all straight from flip-flops
    // ----------------------------------------
    assign o_rdata                = rdata_r;
    assign o_serial_transmit_a    = pins_r[0][6];
    assign o_user_output_two_a    = pins_r[0][5];
    assign o_request_to_send_a    = pins_r[0][4];
    assign o_terminal_ready_a     = pins_r[0][3];
    assign o_interrupt_out_a      = pins_r[0][2];
    assign o_transmit_ready_a     = pins_r[0][1];
    assign o_multi_function_out_a = pins_r[0][0];
    assign o_serial_transmit_b    = pins_r[1][6];
    assign o_user_output_two_b    = pins_r[1][5];
    assign o_request_to_send_b    = pins_r[1][4];
    assign o_terminal_ready_b     = pins_r[1][3];
    assign o_interrupt_out_b      = pins_r[1][2];
    assign o_transmit_ready_b     = pins_r[1][1];
    assign o_multi_function_out_b = pins_r[1][0];
endmodule : dua_top

// ### shared/dua_cfg.svh
`ifndef DUA_CFG_SVH
`define DUA_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DUA_OFF_DATA     3'h0
`define DUA_OFF_IER      3'h1
`define DUA_OFF_ISR_FCR  3'h2
`define DUA_OFF_LCR      3'h3
`define DUA_OFF_MCR      3'h4
`define DUA_OFF_LSR      3'h5
`define DUA_OFF_MSR      3'h6
`define DUA_OFF_SCRATCH  3'h7

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DUA_AFR_DUAL_BIT 0
`define DUA_AFR_MF_LO    1
`define DUA_AFR_MF_HI    2
`define DUA_AFR_USED     3
`define DUA_LCR_DLAB_BIT 7
`define DUA_MCR_DTR_BIT  0
`define DUA_MCR_RTS_BIT  1
`define DUA_MCR_OP2_BIT  3
`define DUA_MSR_RI_BIT   2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DUA_RST_ZERO     8'h00
`define DUA_RST_ISR      8'h01
`define DUA_RST_LSR      8'h60
`define DUA_RST_PINS     7'h79

`endif

// ### shared/dua_chan_if.sv
`timescale 1ns/1ps
interface dua_chan_if;
    logic              we;
    logic              re;
    logic [2:0]        addr;
    dua_pkg::dua_byte_t wdata;
    dua_pkg::dua_byte_t rdata;
    dua_pkg::dua_byte_t line_control_register;
    dua_pkg::dua_byte_t modem_control_register;
    logic [3:0]        modem_n;
    dua_pkg::dua_byte_t int_status;
    dua_pkg::dua_byte_t line_status;

    modport top  (output we, re, addr, wdata, modem_n, int_status, line_status,
                  input  rdata, line_control_register, modem_control_register);
    modport chan (input  we, re, addr, wdata, modem_n, int_status, line_status,
                  output rdata, line_control_register, modem_control_register);
endinterface : dua_chan_if

// ### shared/dua_pkg.sv
package dua_pkg;
    typedef logic [7:0] dua_byte_t;

    // Multi-function pin source codes
    typedef enum logic [1:0] {
        DUA_MF_OP2  = 2'h0,
        DUA_MF_BAUD = 2'h1,
        DUA_MF_RECEIVE_READY_INDICATION = 2'h2,
        DUA_MF_RSVD = 2'h3
    } dua_mf_sel_t;
endpackage : dua_pkg

// ### verification/dua_host_model.sv
`timescale 1ns/1ps
module dua_host_model (
    // Clock
    input  wire logic       i_core_clk,
    // Strobes and data towards the device
    output logic            o_channel_select,
    output logic [2:0]      o_addr,
    output logic            o_wr,
    output logic            o_rd,
    output logic [7:0]      o_wdata,
    // Read data back
    input  wire logic [7:0] i_rdata
);
    // Idle bus from time zero
    initial begin
        o_channel_select = 1'b0;
        o_addr           = 3'h0;
        o_wr             = 1'b0;
        o_rd             = 1'b0;
        o_wdata          = 8'h00;
    end

    // One write; entered after a falling edge, leaves an idle cycle behind
    task automatic wr(input logic ch, input logic [2:0] a, input logic [7:0] d);
        o_channel_select = ch;
        o_addr           = a;
        o_wdata          = d;
        o_wr             = 1'b1;
        @(negedge i_core_clk);
        o_wr    = 1'b0;
        o_wdata = ~d; // Released bus must not keep the last byte
        @(negedge i_core_clk);
    endtask : wr

    // One read; the byte has settled by the second falling edge
    task automatic rd(input logic ch, input logic [2:0] a, output logic [7:0] d);
        o_channel_select = ch;
        o_addr           = a;
        o_rd             = 1'b1;
        @(negedge i_core_clk);
        o_rd = 1'b0;
        @(negedge i_core_clk);
        d = i_rdata;
    endtask : rd
endmodule : dua_host_model

// ### verification/dua_top_asserts.sv
`timescale 1ns/1ps
module dua_top_asserts (
    // Clock and reset
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    // Host register port
    input  wire logic       i_channel_select,
    input  wire logic [2:0] i_addr,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    input  wire logic [7:0] i_wdata,
    input  wire logic [7:0] o_rdata,
    // Channel A datapath levels
    input  wire logic       i_tx_serial_a,
    input  wire logic       i_int_req_a,
    input  wire logic       i_tx_ready_a,
    // Channel A pins
    input  wire logic       o_serial_transmit_a,
    input  wire logic       o_user_output_two_a,
    input  wire logic       o_request_to_send_a,
    input  wire logic       o_terminal_ready_a,
    input  wire logic       o_interrupt_out_a,
    input  wire logic       o_transmit_ready_a,
    input  wire logic       o_multi_function_out_a,
    // Channel B pins
    input  wire logic       o_serial_transmit_b,
    input  wire logic       o_user_output_two_b,
    input  wire logic       o_request_to_send_b,
    input  wire logic       o_terminal_ready_b,
    input  wire logic       o_interrupt_out_b,
    input  wire logic       o_transmit_ready_b,
    input  wire logic       o_multi_function_out_b
);
    // ----------------------------------------
    // Pin and port checks
    // ----------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    // Conservative: any write to offset 2 may have moved the source select
    logic afr_touched_r;
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            afr_touched_r <= 1'b0;
        end else if (i_wr && i_addr == 3'h2) begin
            afr_touched_r <= 1'b1;
        end
    end

    // Modem control write aimed at one channel
    sequence s_mcr_wr(logic ch);
        i_wr && i_channel_select == ch && i_addr == 3'h4;
    endsequence

    // Second edge of reset, so power-up unknowns are skipped
    a_reset_pins_a: assert property (disable iff (1'b0) i_rst && $past(i_rst) |->
        {o_serial_transmit_a, o_user_output_two_a, o_request_to_send_a, o_terminal_ready_a,
         o_multi_function_out_a, o_interrupt_out_a, o_transmit_ready_a} == 7'h7C
        && o_rdata == 8'h00) else $error("channel A pins wrong in reset");
    b_reset_pins_a: assert property (disable iff (1'b0) i_rst && $past(i_rst) |->
        {o_serial_transmit_b, o_user_output_two_b, o_request_to_send_b, o_terminal_ready_b,
         o_multi_function_out_b, o_interrupt_out_b, o_transmit_ready_b} == 7'h7C)
        else $error("channel B pins wrong in reset");
    a_follow_a: assert property (!$past(i_rst) |->
        {o_serial_transmit_a, o_interrupt_out_a, o_transmit_ready_a}
        == $past({i_tx_serial_a, i_int_req_a, i_tx_ready_a})) else $error("A pins lag inputs");
    a_modem_pins_a: assert property (s_mcr_wr(1'b0) |-> ##2
        {o_user_output_two_a, o_request_to_send_a, o_terminal_ready_a}
        == ~$past({i_wdata[3], i_wdata[1:0]}, 2)) else $error("A modem pins wrong");
    b_modem_pins_a: assert property (s_mcr_wr(1'b1) |-> ##2
        {o_user_output_two_b, o_request_to_send_b, o_terminal_ready_b}
        == ~$past({i_wdata[3], i_wdata[1:0]}, 2)) else $error("B modem pins wrong");
    rdata_hold_a: assert property (!i_rd && !$past(i_rd) |-> $stable(o_rdata))
        else $error("read data moved without a read");
    a_mf_default_a: assert property (!afr_touched_r |->
        o_multi_function_out_a == o_user_output_two_a) else $error("A mf pin not op2");
    b_mf_default_a: assert property (!afr_touched_r |->
        o_multi_function_out_b == o_user_output_two_b) else $error("B mf pin not op2");
endmodule : dua_top_asserts

bind dua_top dua_top_asserts u_chk (.*);

// ### verification/tb.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fail_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    logic       i_core_clk = 1'b0;
    logic       i_rst      = 1'b1;
    logic       i_channel_select, i_wr, i_rd;
    logic [2:0] i_addr;
    logic [7:0] i_wdata, o_rdata;
    logic [7:0] i_int_status_a = 8'h01, i_int_status_b = 8'h01;
    logic [7:0] i_line_status_a = 8'h60, i_line_status_b = 8'h60;
    logic [3:0] i_modem_n_a = 4'hA, i_modem_n_b = 4'h3;
    logic i_tx_serial_a = 1'b1, i_int_req_a = 1'b0, i_tx_ready_a = 1'b0;
    logic i_tx_serial_b = 1'b1, i_int_req_b = 1'b0, i_tx_ready_b = 1'b0;
    logic i_rx_ready_a = 1'b0, i_baud_clk_a = 1'b0, i_rx_ready_b = 1'b0, i_baud_clk_b = 1'b0;
    logic o_serial_transmit_a, o_user_output_two_a, o_request_to_send_a, o_terminal_ready_a;
    logic o_interrupt_out_a, o_transmit_ready_a, o_multi_function_out_a;
    logic o_serial_transmit_b, o_user_output_two_b, o_request_to_send_b, o_terminal_ready_b;
    logic o_interrupt_out_b, o_transmit_ready_b, o_multi_function_out_b;
    int   fail_count      = 0;
    int   samples_checked = 0;

    dua_top u_dut (.*);
    dua_host_model u_host (.i_core_clk(i_core_clk), .o_channel_select(i_channel_select),
        .o_addr(i_addr), .o_wr(i_wr), .o_rd(i_rd), .o_wdata(i_wdata), .i_rdata(o_rdata));

    // 200 MHz clock
    initial begin
        forever #2.5 i_core_clk = ~i_core_clk;
    end

    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict

    task automatic rd_chk(input logic ch, input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] got;
        u_host.rd(ch, a, got);
        `CHK(got, exp)
    endtask : rd_chk

    // Reset for six cycles, then IER, LCR, MCR, ISR and LSR of both channels, both MSRs and the AFR
    task automatic t_reset(input logic [3:0] m);
        i_modem_n_a = m;
        i_rst       = 1'b1;
        repeat (6) @(negedge i_core_clk);
        i_rst = 1'b0;
        @(negedge i_core_clk);
        for (int c = 0; c < 2; c++) begin
            rd_chk(c[0], 3'h1, 8'h00);
            rd_chk(c[0], 3'h3, 8'h00);
            rd_chk(c[0], 3'h4, 8'h00);
            rd_chk(c[0], 3'h2, 8'h01);
            rd_chk(c[0], 3'h5, 8'h60);
        end
        rd_chk(1'b0, 3'h6, {~m, 4'h0});
        rd_chk(1'b1, 3'h6, {~i_modem_n_b, 4'h0});
        u_host.wr(1'b0, 3'h3, 8'h80);
        rd_chk(1'b0, 3'h2, 8'h00);
    endtask : t_reset

    // Single-channel writes stay in their own channel
    task automatic t_scratch;
        u_host.wr(1'b0, 3'h7, 8'h5A);
        u_host.wr(1'b1, 3'h7, 8'hA5);
        u_host.wr(1'b1, 3'h4, 8'h03);
        `CHK({o_request_to_send_b, o_terminal_ready_b, o_request_to_send_a}, 3'h1)
        rd_chk(1'b0, 3'h7, 8'h5A);
        rd_chk(1'b1, 3'h7, 8'hA5);
    endtask : t_scratch

    // Dual write on through A, off through B; reads still follow the select
    task automatic t_dual;
        u_host.wr(1'b0, 3'h2, 8'hFF);
        rd_chk(1'b0, 3'h2, 8'h07);
        rd_chk(1'b1, 3'h7, 8'hA5);
        u_host.wr(1'b0, 3'h3, 8'h80);
        rd_chk(1'b1, 3'h3, 8'h80);
        u_host.wr(1'b1, 3'h7, 8'h3C);
        rd_chk(1'b0, 3'h7, 8'h3C);
        u_host.wr(1'b1, 3'h2, 8'h00);
        u_host.wr(1'b0, 3'h7, 8'h11);
        rd_chk(1'b1, 3'h7, 8'h3C);
        rd_chk(1'b0, 3'h7, 8'h11);
    endtask : t_dual

    // Each source select; only the chosen source is active, all are for reserved
    task automatic t_mf;
        logic m3, bd, rx;
        for (int s = 0; s < 4; s++) begin
            m3 = (s == 0 || s == 3);
            bd = (s == 1 || s == 3);
            rx = (s == 2 || s == 3);
            u_host.wr(1'b0, 3'h2, {5'h00, s[1:0], 1'b1});
            u_host.wr(1'b0, 3'h4, {4'h0, m3, 3'h0});
            {i_baud_clk_a, i_baud_clk_b, i_rx_ready_a, i_rx_ready_b} = {bd, bd, rx, rx};
            {i_tx_serial_a, i_int_req_a, i_tx_ready_a} = {s[0], s[1], ~s[0]};
            {i_tx_serial_b, i_int_req_b, i_tx_ready_b} = {~s[0], s[0], s[1]};
            repeat (2) @(negedge i_core_clk);
            `CHK({o_user_output_two_a, o_user_output_two_b}, {~m3, ~m3})
            `CHK({o_multi_function_out_a, o_multi_function_out_b}, {2{s == 3}})
            `CHK({o_serial_transmit_a, o_interrupt_out_a, o_transmit_ready_a}, {s[0], s[1], ~s[0]})
            `CHK({o_serial_transmit_b, o_interrupt_out_b, o_transmit_ready_b}, {~s[0], s[0], s[1]})
        end
    endtask : t_mf

    // Main sequence, with a second reset as the last step before the verdict
    initial begin
        t_reset(4'hA);
        t_scratch();
        t_dual();
        t_mf();
        t_reset(4'h5);
        print_verdict();
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge i_core_clk);
        fail_count++;
        print_verdict();
    end
endmodule : tb
